/* File: verilog/bsid_pkg.sv */
// Package for the boundary-scan instruction decoder: codes, sizes, types
package bsid_pkg;

	// ----------------------------------------------------------------
	// Register sizes
	// ----------------------------------------------------------------
	localparam int IR_W = 8;
	localparam int BSR_W = 113;
	localparam int ID_W = 32;
	localparam int RESET_ONES = 5;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_EXTEST = 8'h00;
	localparam logic [7:0] OP_IDCODE = 8'h21;
	localparam logic [7:0] OP_SAMPLE = 8'h05;
	localparam logic [7:0] OP_CLAMP = 8'h07;
	localparam logic [7:0] OP_HIGHZ = 8'h03;
	localparam logic [7:0] OP_BYPASS = 8'hFF;
	localparam logic [1:0] IR_CAPTURE = 2'h1;

	// Arbitrary neutral identification value
	localparam logic [31:0] ID_VALUE_DEFAULT = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BSID_SEL_BYPASS,
		BSID_SEL_BSR,
		BSID_SEL_ID
	} bsid_sel_t;

	typedef enum logic [1:0] {
		BSID_OUT_NORMAL,
		BSID_OUT_BSR,
		BSID_OUT_HIGHZ
	} bsid_outmode_t;

	typedef struct packed {
		bsid_sel_t sel;
		bsid_outmode_t outmode;
		logic normal_ok;
	} bsid_decode_t;

	// Decoded controller states, on the test clock; each is high for as long as its state lasts
	typedef struct packed {
		logic tlr;
		logic capture_ir;
		logic shift_ir;
		logic update_ir;
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
	} bsid_tap_t;

endpackage : bsid_pkg

/* File: verilog/bsid_tapfsm.sv */
// TAP state machine of the boundary-scan port
`timescale 1ns/1ns
module bsid_tapfsm (
	input wire logic i_tck,
	input wire logic i_reset,
	input wire logic i_tms,
	output bsid_pkg::bsid_tap_t o_tap
);

	typedef enum logic [3:0] {
		TLR, RTI, SDRS, CDR, SHDR, E1DR, PDR, E2DR, UDR,
		SIRS, CIR, SHIR, E1IR, PIR, E2IR, UIR
	} bsid_state_t;

	bsid_state_t state_q;
	bsid_state_t state_d;

	always_comb begin
		case (state_q)
			TLR: state_d = i_tms ? TLR : RTI;
			RTI: state_d = i_tms ? SDRS : RTI;
			SDRS: state_d = i_tms ? SIRS : CDR;
			CDR: state_d = i_tms ? E1DR : SHDR;
			SHDR: state_d = i_tms ? E1DR : SHDR;
			E1DR: state_d = i_tms ? UDR : PDR;
			PDR: state_d = i_tms ? E2DR : PDR;
			E2DR: state_d = i_tms ? UDR : SHDR;
			UDR: state_d = i_tms ? SDRS : RTI;
			SIRS: state_d = i_tms ? TLR : CIR;
			CIR: state_d = i_tms ? E1IR : SHIR;
			SHIR: state_d = i_tms ? E1IR : SHIR;
			E1IR: state_d = i_tms ? UIR : PIR;
			PIR: state_d = i_tms ? E2IR : PIR;
			E2IR: state_d = i_tms ? UIR : SHIR;
			UIR: state_d = i_tms ? SDRS : RTI;
			default: state_d = TLR;
		endcase
	end

	// Five high TMS edges reach TLR from any state
	always_ff @(posedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			state_q <= TLR;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_tap.tlr = (state_q == TLR);
	assign o_tap.capture_ir = (state_q == CIR);
	assign o_tap.shift_ir = (state_q == SHIR);
	assign o_tap.update_ir = (state_q == UIR);
	assign o_tap.capture_dr = (state_q == CDR);
	assign o_tap.shift_dr = (state_q == SHDR);
	assign o_tap.update_dr = (state_q == UDR);

endmodule : bsid_tapfsm

/* File: verilog/bsid_decode.sv */
// Instruction decoder: maps the active code to scan path and ball mode
`timescale 1ns/1ns
module bsid_decode (
	input wire logic [7:0] i_ir,
	output bsid_pkg::bsid_decode_t o_dec
);

	wire is_extest = (i_ir == bsid_pkg::OP_EXTEST);
	wire is_id = (i_ir == bsid_pkg::OP_IDCODE);
	wire is_sample = (i_ir == bsid_pkg::OP_SAMPLE);
	wire is_clamp = (i_ir == bsid_pkg::OP_CLAMP);
	wire is_highz = (i_ir == bsid_pkg::OP_HIGHZ);

	// Scan path: the table's bypass reading is taken for high-Z
	assign o_dec.sel = (is_extest || is_sample) ? bsid_pkg::BSID_SEL_BSR
		: is_id ? bsid_pkg::BSID_SEL_ID
		: bsid_pkg::BSID_SEL_BYPASS;

	assign o_dec.outmode = (is_extest || is_clamp)
		? bsid_pkg::BSID_OUT_BSR
		: is_highz ? bsid_pkg::BSID_OUT_HIGHZ
		: bsid_pkg::BSID_OUT_NORMAL;

	// Normal memory operation left untouched
	assign o_dec.normal_ok = !(is_clamp || is_highz || is_extest)
		|| is_extest;

endmodule : bsid_decode

/* File: verilog/bsid_top.sv */
// Boundary-scan instruction decoder and data-register paths, top level
`timescale 1ns/1ns

// Notes on behaviour
// - Instruction register is eight bits wide
// - Shift-IR puts instruction register on scan path
// - New instruction acts only at update-IR
// - Code 00h: external test, boundary register path
// - External test drives boundary values on balls
// - Code 21h: 32-bit ID on scan path
// - ID instruction active after reset, TLR
// - Code 05h: sample balls, boundary register path
// - Code 07h: bypass path, balls hold boundary
// - Code 03h: bypass path, balls float
// - Code FFh: one-bit bypass path
// - Extest, ID, bypass leave memory undisturbed
// - Capture-IR loads 01 into low bits
// - Boundary register 113 bits, LSB to TDO
// - TDO updates on every falling edge, enabled in shift only
// - Five high TMS edges enter TLR
module bsid_top (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_TCK,
	input wire logic I_TMS,
	input wire logic I_TDI,
	input wire logic [112:0] I_BALL_IN,
	input wire logic [112:0] I_FUNC_OUT,
	output logic O_TDO,
	output logic O_TDO_OE,
	output logic [112:0] O_BALL_OUT,
	output logic O_BALL_HIGHZ,
	output logic O_NORMAL_OK
);

	// ----------------------------------------------------------------
	// Reset synchronised to the test clock domain
	// ----------------------------------------------------------------
	logic trst_meta_q;
	logic trst_q;

	always_ff @(posedge I_TCK or posedge I_RESET) begin
		if (I_RESET) begin
			trst_meta_q <= 1'b1;
			trst_q <= 1'b1;
		end else begin
			trst_meta_q <= 1'b0;
			trst_q <= trst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Controller
	// ----------------------------------------------------------------
	bsid_pkg::bsid_tap_t tap;

	bsid_tapfsm u_fsm (
		.i_tck(I_TCK),
		.i_reset(trst_q),
		.i_tms(I_TMS),
		.o_tap(tap)
	);

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	logic [bsid_pkg::IR_W-1:0] ir_sh_q;
	logic [bsid_pkg::IR_W-1:0] ir_q;

	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			ir_sh_q <= bsid_pkg::OP_IDCODE;
		end else if (tap.capture_ir) begin
			ir_sh_q <= {ir_q[bsid_pkg::IR_W-1:2], bsid_pkg::IR_CAPTURE};
		end else if (tap.shift_ir) begin
			ir_sh_q <= {I_TDI, ir_sh_q[bsid_pkg::IR_W-1:1]};
		end
	end

	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			ir_q <= bsid_pkg::OP_IDCODE;
		end else if (tap.tlr) begin
			ir_q <= bsid_pkg::OP_IDCODE;
		end else if (tap.update_ir) begin
			ir_q <= ir_sh_q;
		end
	end

	bsid_pkg::bsid_decode_t dec;

	bsid_decode u_dec (
		.i_ir(ir_q),
		.o_dec(dec)
	);

	// ----------------------------------------------------------------
	// Ball inputs synchronised into the test clock domain
	// ----------------------------------------------------------------
	// Memory-clock balls may still mis-sample; software ignores them
	logic [bsid_pkg::BSR_W-1:0] ball_meta_q;
	logic [bsid_pkg::BSR_W-1:0] ball_sync_q;

	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			ball_meta_q <= '0;
			ball_sync_q <= '0;
		end else begin
			ball_meta_q <= I_BALL_IN;
			ball_sync_q <= ball_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	logic [bsid_pkg::BSR_W-1:0] bsr_q;
	logic [bsid_pkg::BSR_W-1:0] bsr_upd_q;
	logic [bsid_pkg::ID_W-1:0] id_q;
	logic byp_q;

	wire sel_bsr = (dec.sel == bsid_pkg::BSID_SEL_BSR);
	wire sel_id = (dec.sel == bsid_pkg::BSID_SEL_ID);
	wire sel_byp = (dec.sel == bsid_pkg::BSID_SEL_BYPASS);

	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			bsr_q <= '0;
		end else if (sel_bsr && tap.capture_dr) begin
			bsr_q <= ball_sync_q;
		end else if (sel_bsr && tap.shift_dr) begin
			bsr_q <= {I_TDI, bsr_q[bsid_pkg::BSR_W-1:1]};
		end
	end

	// Parallel latch changes only at update-DR
	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			bsr_upd_q <= '0;
		end else if (sel_bsr && tap.update_dr) begin
			bsr_upd_q <= bsr_q;
		end
	end

	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			id_q <= '0;
		end else if (sel_id && tap.capture_dr) begin
			id_q <= bsid_pkg::ID_VALUE_DEFAULT;
		end else if (sel_id && tap.shift_dr) begin
			id_q <= {I_TDI, id_q[bsid_pkg::ID_W-1:1]};
		end
	end

	always_ff @(posedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			byp_q <= 1'b0;
		end else if (sel_byp && tap.capture_dr) begin
			byp_q <= 1'b0;
		end else if (sel_byp && tap.shift_dr) begin
			byp_q <= I_TDI;
		end
	end

	// ----------------------------------------------------------------
	// TDO on the falling test clock edge
	// ----------------------------------------------------------------
	wire dr_bit = sel_bsr ? bsr_q[0] : sel_id ? id_q[0] : byp_q;
	wire tdo_d = tap.shift_ir ? ir_sh_q[0] : dr_bit;
	wire tdo_oe_d = tap.shift_ir || tap.shift_dr;

	always_ff @(negedge I_TCK or posedge trst_q) begin
		if (trst_q) begin
			O_TDO <= 1'b0;
			O_TDO_OE <= 1'b0;
		end else begin
			O_TDO <= tdo_d;
			O_TDO_OE <= tdo_oe_d;
		end
	end

	// ----------------------------------------------------------------
	// Ball control, crossed into the memory clock domain
	// ----------------------------------------------------------------
	// Mode changes only at update-IR and TLR, latch at update-DR, so a two-stage
	// level sync is enough; a multi-bit skew lasts one memory cycle.
	logic [1:0] mode_meta_q;
	logic [1:0] mode_q;
	logic ok_meta_q;
	logic [bsid_pkg::BSR_W-1:0] val_meta_q;
	logic [bsid_pkg::BSR_W-1:0] val_q;
	logic ok_q;

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			mode_meta_q <= bsid_pkg::BSID_OUT_NORMAL;
			mode_q <= bsid_pkg::BSID_OUT_NORMAL;
			ok_meta_q <= 1'b1;
			ok_q <= 1'b1;
			val_meta_q <= '0;
			val_q <= '0;
		end else begin
			mode_meta_q <= dec.outmode;
			mode_q <= mode_meta_q;
			ok_meta_q <= dec.normal_ok;
			ok_q <= ok_meta_q;
			val_meta_q <= bsr_upd_q;
			val_q <= val_meta_q;
		end
	end

	wire drive_bsr = (mode_q == bsid_pkg::BSID_OUT_BSR);
	wire float_all = (mode_q == bsid_pkg::BSID_OUT_HIGHZ);
	wire [bsid_pkg::BSR_W-1:0] ball_d = drive_bsr ? val_q : I_FUNC_OUT;

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_BALL_OUT <= '0;
			O_BALL_HIGHZ <= 1'b0;
			O_NORMAL_OK <= 1'b1;
		end else begin
			O_BALL_OUT <= ball_d;
			O_BALL_HIGHZ <= float_all;
			O_NORMAL_OK <= ok_q;
		end
	end

endmodule : bsid_top

/* File: tb/bsid_top_sva.sv */
// Port checker for the boundary-scan decoder
`timescale 1ns/1ns
module bsid_top_sva (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_TCK,
	input wire logic I_TMS,
	input wire logic O_TDO,
	input wire logic O_TDO_OE,
	input wire logic O_BALL_HIGHZ,
	input wire logic O_NORMAL_OK
);
	a_tdo_at_fall: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		$changed(O_TDO) |-> !I_TCK) else $error("tdo moved, tck high");
	a_oe_at_fall: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		$changed(O_TDO_OE) |-> !I_TCK) else $error("oe moved, tck high");
	a_oe_min_width: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		$rose(O_TDO_OE) |=> O_TDO_OE[*8]) else $error("oe too short");
	a_hz_held_tck: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		(I_TCK && $past(I_TCK, 8)) |-> $stable(O_BALL_HIGHZ))
		else $error("highz moved late");
	a_nok_after_upd: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		$changed(O_NORMAL_OK) |-> I_TCK && !$past(I_TCK, 8))
		else $error("normal flag moved off an update");
	a_hz_stops_mem: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		O_BALL_HIGHZ |-> !O_NORMAL_OK) else $error("highz with normal");
	a_reset_state: assert property (
		@(posedge I_MCLK) disable iff (I_RESET)
		$fell(I_RESET) |-> !O_TDO_OE && O_NORMAL_OK && !O_BALL_HIGHZ)
		else $error("bad state after reset");
	a_tlr_quiet: assert property (
		@(posedge I_TCK) disable iff (I_RESET)
		I_TMS[*5] |-> ##2 (!O_TDO_OE && O_NORMAL_OK))
		else $error("tlr not quiet");
endmodule : bsid_top_sva
bind bsid_top bsid_top_sva u_sva (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
	.I_TCK(I_TCK), .I_TMS(I_TMS), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
	.O_BALL_HIGHZ(O_BALL_HIGHZ), .O_NORMAL_OK(O_NORMAL_OK));

/* File: tb/bsid_jtag_model.sv */
// Test controller model that drives the scan port
`timescale 1ns/1ns
module bsid_jtag_model (
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
	end
	// 160 ns period stays under the ceiling; TCK idles low between frames
	task automatic step(input logic m, input logic d, output logic t);
		o_tms = m;
		o_tdi = d;
		#80;
		t = i_tdo;
		o_tck = 1'b1;
		#80;
		o_tck = 1'b0;
	endtask : step
	task automatic tlr();
		logic t;
		repeat (5) step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask : tlr
	// Shifts n bits LSB first; TDI returns to its pulled-up level after
	task automatic scan(input logic ir, input int n,
		input logic [127:0] d, output logic [127:0] q);
		logic t;
		q = '0;
		step(1'b1, 1'b1, t);
		if (ir)
			step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], t);
			q[i] = t;
		end
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask : scan
endmodule : bsid_jtag_model

/* File: tb/bsid_top_tb_top.sv */
// Self-checking bench for the boundary-scan decoder
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
	bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module bsid_top_tb_top;
	logic mclk, rst, tck, tms, tdi, tdo, oe, hz, nok;
	logic [112:0] bin, fout, bout, pa;
	logic [127:0] q;
	int bad_count = 0;
	int n_checks = 0;
	bsid_top u_dut (.I_MCLK(mclk), .I_RESET(rst), .I_TCK(tck),
		.I_TMS(tms), .I_TDI(tdi), .I_BALL_IN(bin), .I_FUNC_OUT(fout),
		.O_TDO(tdo), .O_TDO_OE(oe), .O_BALL_OUT(bout),
		.O_BALL_HIGHZ(hz), .O_NORMAL_OK(nok));
	bsid_jtag_model u_jtag (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.i_tdo(tdo));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic ld(input logic [7:0] c);
		u_jtag.scan(1'b1, 8, {120'h0, c}, q);
		`CHK("ir_cap", bsid_pkg::IR_CAPTURE, q[1:0])
	endtask : ld
	task automatic dr(input int n, input logic [112:0] d);
		u_jtag.scan(1'b0, n, {15'h0, d}, q);
	endtask : dr
	task automatic t_id();
		`CHK("oe", 1'b0, oe)
		`CHK("nok", 1'b1, nok)
		dr(32, '0);
		`CHK("id", bsid_pkg::ID_VALUE_DEFAULT, q[31:0])
		ld(bsid_pkg::OP_BYPASS);
		`CHK("ir_old", bsid_pkg::OP_IDCODE, q[7:0])
		dr(9, 113'h1A5);
		`CHK("byp", 9'h14A, q[8:0])
		$display("test id_bypass done");
	endtask : t_id
	task automatic t_modes();
		logic [7:0] c [4] = '{bsid_pkg::OP_CLAMP, bsid_pkg::OP_HIGHZ,
			8'h42, bsid_pkg::OP_BYPASS};
		for (int i = 0; i < 4; i++) begin
			ld(c[i]);
			`CHK("hz", i == 1, hz)
			`CHK("nok", i > 1, nok)
			dr(2, 113'h3);
			`CHK("byp2", 2'h2, q[1:0])
		end
		`CHK("pass", fout, bout)
		$display("test modes done");
	endtask : t_modes
	task automatic t_bsr();
		logic [112:0] r;
		r = {pa[56:0], pa[112:57]};
		ld(bsid_pkg::OP_SAMPLE);
		dr(113, ~pa);
		`CHK("smp", pa, q[112:0])
		ld(bsid_pkg::OP_EXTEST);
		`CHK("pre", ~pa, bout)
		dr(113, r);
		`CHK("ext", pa, q[112:0])
		`CHK("upd", r, bout)
		ld(bsid_pkg::OP_CLAMP);
		`CHK("clamp", r, bout)
		u_jtag.tlr();
		`CHK("tlr", 1'b1, nok)
		dr(32, '0);
		`CHK("id2", bsid_pkg::ID_VALUE_DEFAULT, q[31:0])
		$display("test bsr done");
	endtask : t_bsr
	initial begin
		rst = 1'b1;
		pa = 113'h1_0F0F_3C3C_A5A5_9669_C3C3_5A5A_F00F;
		bin = pa;
		fout = {pa[0], pa[112:1]};
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		u_jtag.tlr();
		t_id();
		t_modes();
		t_bsr();
		end_sim();
	end
	initial begin
		#300000;
		bad_count++;
		end_sim();
	end
endmodule : bsid_top_tb_top
